// ### hdl/addr_compare.sv
`timescale 1ns/1ps
// one comparator's address checks against the current bus address
module addr_compare
   import match_cmp_pkg::*;
(
   input  wire logic [ADDR_W-1:0] cfg_addr,
   input  wire logic [ADDR_W-1:0] bus_addr,
   input  wire logic              word_grain,
   output logic                   addr_equal,
   output logic                   addr_at_or_above,
   output logic                   addr_at_or_below
);

   logic [ADDR_W-1:0] grain_mask;
   logic [ADDR_W-1:0] cfg_m;
   logic [ADDR_W-1:0] bus_m;

   // tagged range bounds only resolve to word granularity, so bit 0 drops out
   assign grain_mask = word_grain ? {{(ADDR_W-1){1'b1}}, 1'b0} : {ADDR_W{1'b1}};
   assign cfg_m      = cfg_addr & grain_mask;
   assign bus_m      = bus_addr & grain_mask;

   // starting address only: a word at n-1 never equals n
   assign addr_equal       = (bus_m == cfg_m);
   assign addr_at_or_above = (bus_m >= cfg_m);
   assign addr_at_or_below = (bus_m <= cfg_m);

endmodule // addr_compare

// ### hdl/data_compare.sv
`timescale 1ns/1ps
// masked data bus compare for the first comparator
module data_compare
   import match_cmp_pkg::*;
(
   input  wire logic [DATA_W-1:0] bus_data,
   input  wire logic [DATA_W-1:0] cmp_data,
   input  wire logic [DATA_W-1:0] cmp_mask,
   input  wire logic              mismatch_mode,
   output logic                   data_hit
);

   logic [DATA_W-1:0] diff_bits;

   // only bits with a set mask take part
   assign diff_bits = (bus_data ^ cmp_data) & cmp_mask;

   // equality: no enabled bit differs, so an empty mask always passes;
   // difference: some enabled bit differs, so an empty mask never passes
   assign data_hit = mismatch_mode ? (|diff_bits)
                                   : ~(|diff_bits);

endmodule // data_compare

// ### hdl/debug_bus_match_comparators.sv
`timescale 1ns/1ps
// What this block does
// - third comparator: exact address plus direction only
// - direction qualify off matches both; select picks
// - second comparator may also qualify transfer size
// - size select 0 word, 1 byte
// - byte-configured comparator ignores covering word transfers
// - first comparator compares data, lower address high
// - mask selects which data bits are compared
// - equality mode: masked bits equal; empty mask passes
// - difference mode: masked bit differs; empty never matches
// - range: first comparator's direction bits govern
// - range mode ignores all size qualification
// - range tagging from first comparator only
// - range halt enable from first comparator only
// - tagged range bounds resolve to word granularity
// - inside: at/above first and at/below second
// - straddling words judged by aligned start address
// - outside: below first or above second
// - all comparators idle in background debug
// - tagging ignores qualifiers and data; exact address, or the window in range mode
module debug_bus_match_comparators
   import match_cmp_pkg::*;
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // watched cpu system bus
   input  wire logic              bus_valid,
   input  wire logic [ADDR_W-1:0] bus_addr,
   input  wire logic [DATA_W-1:0] bus_data,
   input  wire logic              bus_read,
   input  wire logic              bus_word,
   input  wire logic              background_debug_state,
   input  wire logic              background_debug_access,
   // match outputs toward sequencer, tag logic and breakpoint logic
   output logic [NUM_CH-1:0]      match_forced,
   output logic [NUM_CH-1:0]      match_tag_request,
   output logic                   halt_request
);

   // configuration registers
   logic [CTRL_W-1:0]  first_comparator_control_ff;
   logic [CTRL_W-1:0]  second_comparator_control_ff;
   logic [CTRL_W-1:0]  third_comparator_control_ff;
   logic [ADDR_W-1:0]  first_addr_ff;
   logic [ADDR_W-1:0]  second_addr_ff;
   logic [ADDR_W-1:0]  third_addr_ff;
   logic [DATA_W-1:0]  data_compare_ff;
   logic [DATA_W-1:0]  data_mask_ff;
   logic [RANGE_W-1:0] range_control_ff;
   // status and outputs
   logic [NUM_CH-1:0]  sticky_ff;
   logic [ADDR_W-1:0]  last_addr_ff;
   logic [NUM_CH-1:0]  match_forced_ff;
   logic [NUM_CH-1:0]  match_tag_ff;
   logic               halt_ff;
   logic [31:0]        prdata_ff;

   logic               setup_phase;
   logic               write_take;
   logic               addr_mapped;
   logic [31:0]        nxt_prdata;

   logic               first_comparator_enable;
   logic               second_comparator_enable;
   logic               range_active;
   logic               bus_watch;
   logic [NUM_CH-1:0]  eq;
   logic [NUM_CH-1:0]  at_or_above;
   logic [NUM_CH-1:0]  at_or_below;
   logic               range_word_grain;
   logic               data_hit;
   logic [DATA_W-1:0]  data_compare_high_low;
   logic [NUM_CH-1:0]  hit;
   logic [NUM_CH-1:0]  hit_tagged;
   logic [NUM_CH-1:0]  hit_halt;
   logic               range_hit;

   // direction qualifier shared by all three comparators
   function automatic logic dir_ok(input logic [CTRL_W-1:0] ctrl, input logic rd);
      dir_ok = ~ctrl[BIT_DIR_QUAL] | (ctrl[BIT_DIR_READ] == rd);
   endfunction

   // size qualifier, byte select set means only byte transfers pass
   function automatic logic size_ok(input logic [CTRL_W-1:0] ctrl, input logic word);
      size_ok = ~ctrl[BIT_SZ_QUAL] | (ctrl[BIT_SZ_BYTE] == ~word);
   endfunction

   // register decode helper, used by write and read paths
   function automatic logic is_reg(input logic [11:0] a, input logic [11:0] off);
      is_reg = (a == off);
   endfunction

   // apb slave: zero wait states, read data captured in setup so it comes from a flop
   assign setup_phase = psel & ~penable;
   assign write_take  = psel & penable & pwrite & addr_mapped;
   assign pready      = 1'b1;
   assign pslverr     = psel & penable & ~addr_mapped;
   assign prdata      = prdata_ff;

   assign addr_mapped = is_reg(paddr, OFF_CTRL_A) | is_reg(paddr, OFF_CTRL_B)
                      | is_reg(paddr, OFF_CTRL_C) | is_reg(paddr, OFF_ADDR_A)
                      | is_reg(paddr, OFF_ADDR_B) | is_reg(paddr, OFF_ADDR_C)
                      | is_reg(paddr, OFF_DATA_CMP) | is_reg(paddr, OFF_DATA_MASK)
                      | is_reg(paddr, OFF_RANGE) | is_reg(paddr, OFF_STATUS)
                      | is_reg(paddr, OFF_LAST_ADDR);

   // read mux, narrow registers sit in the low bits with zeros above
   always_comb begin
      nxt_prdata = 32'h0000_0000;
      unique case (1'b1)
         is_reg(paddr, OFF_CTRL_A):    nxt_prdata[CTRL_W-1:0]  = first_comparator_control_ff;
         is_reg(paddr, OFF_CTRL_B):    nxt_prdata[CTRL_W-1:0]  = second_comparator_control_ff;
         is_reg(paddr, OFF_CTRL_C):    nxt_prdata[CTRL_W-1:0]  = third_comparator_control_ff;
         is_reg(paddr, OFF_ADDR_A):    nxt_prdata[ADDR_W-1:0]  = first_addr_ff;
         is_reg(paddr, OFF_ADDR_B):    nxt_prdata[ADDR_W-1:0]  = second_addr_ff;
         is_reg(paddr, OFF_ADDR_C):    nxt_prdata[ADDR_W-1:0]  = third_addr_ff;
         is_reg(paddr, OFF_DATA_CMP):  nxt_prdata[DATA_W-1:0]  = data_compare_ff;
         is_reg(paddr, OFF_DATA_MASK): nxt_prdata[DATA_W-1:0]  = data_mask_ff;
         is_reg(paddr, OFF_RANGE):     nxt_prdata[RANGE_W-1:0] = range_control_ff;
         is_reg(paddr, OFF_STATUS):    nxt_prdata[NUM_CH-1:0]  = sticky_ff;
         is_reg(paddr, OFF_LAST_ADDR): nxt_prdata[ADDR_W-1:0]  = last_addr_ff;
         default:                      nxt_prdata              = 32'h0000_0000;
      endcase
   end

   // read data is latched in the setup cycle, a write in the access cycle
   // cannot change it in the same transfer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
      end else if (setup_phase) begin
         prdata_ff <= nxt_prdata;
      end
   end

   // comparator control and address registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_comparator_control_ff  <= CTRL_RST;
         second_comparator_control_ff <= CTRL_RST;
         third_comparator_control_ff  <= CTRL_RST;
         first_addr_ff                <= ADDR_RST;
         second_addr_ff               <= ADDR_RST;
         third_addr_ff                <= ADDR_RST;
      end else if (write_take) begin
         if (is_reg(paddr, OFF_CTRL_A)) first_comparator_control_ff  <= pwdata[CTRL_W-1:0];
         if (is_reg(paddr, OFF_CTRL_B)) second_comparator_control_ff <= pwdata[CTRL_W-1:0];
         if (is_reg(paddr, OFF_CTRL_C)) third_comparator_control_ff  <= pwdata[CTRL_W-1:0];
         if (is_reg(paddr, OFF_ADDR_A)) first_addr_ff  <= pwdata[ADDR_W-1:0];
         if (is_reg(paddr, OFF_ADDR_B)) second_addr_ff <= pwdata[ADDR_W-1:0];
         if (is_reg(paddr, OFF_ADDR_C)) third_addr_ff  <= pwdata[ADDR_W-1:0];
      end
   end

   // data compare, mask and range mode registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_compare_ff  <= DATA_RST;
         data_mask_ff     <= DATA_RST;
         range_control_ff <= RANGE_RST;
      end else if (write_take) begin
         if (is_reg(paddr, OFF_DATA_CMP))  data_compare_ff  <= pwdata[DATA_W-1:0];
         if (is_reg(paddr, OFF_DATA_MASK)) data_mask_ff     <= pwdata[DATA_W-1:0];
         if (is_reg(paddr, OFF_RANGE))     range_control_ff <= pwdata[RANGE_W-1:0];
      end
   end

   // comparator datapath
   assign first_comparator_enable  = first_comparator_control_ff[BIT_ENABLE];
   assign second_comparator_enable = second_comparator_control_ff[BIT_ENABLE];

   // the pair works as a range only with both enables set; a half-set pair
   // drops back to two single comparators rather than a lopsided range
   assign range_active = (range_control_ff != RANGE_OFF)
                       & first_comparator_enable & second_comparator_enable;

   // nothing is watched while background debug owns the bus
   assign bus_watch = bus_valid & ~background_debug_state
                    & ~background_debug_access;

   assign range_word_grain = range_active & first_comparator_control_ff[BIT_TAG];

   // high data byte belongs to the lower address of a word
   assign data_compare_high_low = {data_compare_ff[DATA_HI_LSB +: BYTE_W],
                                   data_compare_ff[DATA_LO_LSB +: BYTE_W]};

   addr_compare u_addr_first (
      .cfg_addr         (first_addr_ff),
      .bus_addr         (bus_addr),
      .word_grain       (range_word_grain),
      .addr_equal       (eq[0]),
      .addr_at_or_above (at_or_above[0]),
      .addr_at_or_below (at_or_below[0])
   );

   addr_compare u_addr_second (
      .cfg_addr         (second_addr_ff),
      .bus_addr         (bus_addr),
      .word_grain       (range_word_grain),
      .addr_equal       (eq[1]),
      .addr_at_or_above (at_or_above[1]),
      .addr_at_or_below (at_or_below[1])
   );

   addr_compare u_addr_third (
      .cfg_addr         (third_addr_ff),
      .bus_addr         (bus_addr),
      .word_grain       (1'b0),
      .addr_equal       (eq[2]),
      .addr_at_or_above (at_or_above[2]),
      .addr_at_or_below (at_or_below[2])
   );

   data_compare u_data (
      .bus_data      (bus_data),
      .cmp_data      (data_compare_high_low),
      .cmp_mask      (data_mask_ff),
      .mismatch_mode (first_comparator_control_ff[BIT_MISMATCH]),
      .data_hit      (data_hit)
   );

   // range window on the aligned start address, so a straddling word is
   // judged by where it begins
   always_comb begin
      range_hit = 1'b0;
      if (range_control_ff == RANGE_INSIDE) begin
         range_hit = at_or_above[0] & at_or_below[1];
      end else if (range_control_ff == RANGE_OUTSIDE) begin
         range_hit = ~at_or_above[0] | ~at_or_below[1];
      end
   end

   // channel hits; tagging drops every qualifier and the data compare
   always_comb begin
      hit        = CH_RST;
      hit_tagged = CH_RST;
      hit_halt   = CH_RST;
      if (bus_watch) begin
         if (range_active) begin
            // pair uses the first comparator's direction, tag and halt bits,
            // size bits of both are ignored
            hit[0] = range_hit & (first_comparator_control_ff[BIT_TAG]
                   | (dir_ok(first_comparator_control_ff, bus_read) & data_hit));
            hit_tagged[0] = first_comparator_control_ff[BIT_TAG];
            hit_halt[0]   = first_comparator_control_ff[BIT_HALT];
         end else begin
            hit[0] = first_comparator_enable & eq[0]
                   & (first_comparator_control_ff[BIT_TAG]
                   | (dir_ok(first_comparator_control_ff, bus_read)
                   & size_ok(first_comparator_control_ff, bus_word) & data_hit));
            hit[1] = second_comparator_enable & eq[1]
                   & (second_comparator_control_ff[BIT_TAG]
                   | (dir_ok(second_comparator_control_ff, bus_read)
                   & size_ok(second_comparator_control_ff, bus_word)));
            hit_tagged[0] = first_comparator_control_ff[BIT_TAG];
            hit_tagged[1] = second_comparator_control_ff[BIT_TAG];
            hit_halt[0]   = first_comparator_control_ff[BIT_HALT];
            hit_halt[1]   = second_comparator_control_ff[BIT_HALT];
         end
         hit[2] = third_comparator_control_ff[BIT_ENABLE] & eq[2]
                & (third_comparator_control_ff[BIT_TAG]
                | dir_ok(third_comparator_control_ff, bus_read));
         hit_tagged[2] = third_comparator_control_ff[BIT_TAG];
         hit_halt[2]   = third_comparator_control_ff[BIT_HALT];
      end
   end

   // outputs: one-cycle pulses, one clock after the matching bus cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_forced_ff <= CH_RST;
         match_tag_ff    <= CH_RST;
         halt_ff         <= 1'b0;
      end else begin
         match_forced_ff <= hit & ~hit_tagged;
         match_tag_ff    <= hit & hit_tagged;
         halt_ff         <= |(hit & hit_halt);
      end
   end

   assign match_forced      = match_forced_ff;
   assign match_tag_request = match_tag_ff;
   assign halt_request      = halt_ff;

   // sticky hit flags, write one to clear; a hit in the clearing cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sticky_ff <= CH_RST;
      end else begin
         sticky_ff <= (sticky_ff & ~((write_take & is_reg(paddr, OFF_STATUS))
                    ? pwdata[NUM_CH-1:0] : CH_RST)) | hit;
      end
   end

   // address of the most recent matching bus cycle, for software post-mortem
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_addr_ff <= ADDR_RST;
      end else if (|hit) begin
         last_addr_ff <= bus_addr;
      end
   end

endmodule // debug_bus_match_comparators

// ### hdl/match_cmp_pkg.sv
package match_cmp_pkg;

   // widths of the watched system buses
   localparam int ADDR_W = 18;
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;
   localparam int CTRL_W = 8;
   localparam int NUM_CH = 3;

   // apb register byte offsets
   localparam logic [11:0] OFF_CTRL_A    = 12'h000;
   localparam logic [11:0] OFF_CTRL_B    = 12'h004;
   localparam logic [11:0] OFF_CTRL_C    = 12'h008;
   localparam logic [11:0] OFF_ADDR_A    = 12'h00c;
   localparam logic [11:0] OFF_ADDR_B    = 12'h010;
   localparam logic [11:0] OFF_ADDR_C    = 12'h014;
   localparam logic [11:0] OFF_DATA_CMP  = 12'h018;
   localparam logic [11:0] OFF_DATA_MASK = 12'h01c;
   localparam logic [11:0] OFF_RANGE     = 12'h020;
   localparam logic [11:0] OFF_STATUS    = 12'h024;
   localparam logic [11:0] OFF_LAST_ADDR = 12'h028;

   // comparator control field positions
   localparam int BIT_ENABLE   = 0;
   localparam int BIT_DIR_QUAL = 1;
   localparam int BIT_DIR_READ = 2;
   localparam int BIT_SZ_QUAL  = 3;
   localparam int BIT_SZ_BYTE  = 4;
   localparam int BIT_TAG      = 5;
   localparam int BIT_HALT     = 6;
   localparam int BIT_MISMATCH = 7;

   // data register field positions: high byte over bits 15:8
   localparam int DATA_HI_LSB = 8;
   localparam int DATA_LO_LSB = 0;

   // range control encodings, in bits 1:0 of the range register
   localparam int RANGE_W = 2;
   localparam logic [RANGE_W-1:0] RANGE_OFF     = 2'h0;
   localparam logic [RANGE_W-1:0] RANGE_INSIDE  = 2'h1;
   localparam logic [RANGE_W-1:0] RANGE_OUTSIDE = 2'h2;

   // reset values
   localparam logic [CTRL_W-1:0]  CTRL_RST  = 8'h00;
   localparam logic [ADDR_W-1:0]  ADDR_RST  = 18'h00000;
   localparam logic [DATA_W-1:0]  DATA_RST  = 16'h0000;
   localparam logic [RANGE_W-1:0] RANGE_RST = 2'h0;
   localparam logic [NUM_CH-1:0]  CH_RST    = 3'h0;

endpackage

// ### verif/cpu_bus_model.sv
`timescale 1ns/1ps
// cpu side of the watched system bus; one call makes one bus cycle
module cpu_bus_model
   import match_cmp_pkg::*;
(
   input  wire logic              pclk,
   output logic                   bus_valid,
   output logic [ADDR_W-1:0]      bus_addr,
   output logic [DATA_W-1:0]      bus_data,
   output logic                   bus_read,
   output logic                   bus_word
);
   // idle pattern, never a clean zero
   initial begin
      bus_valid = 1'b0;
      bus_addr  = 18'h2aaaa;
      bus_data  = 16'h5555;
      bus_read  = 1'b1;
      bus_word  = 1'b0;
   end

   // aligned start address; then the inverse so stale values never match
   task automatic cycle(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        input logic rd, input logic wd);
      @(posedge pclk);
      bus_valid <= 1'b1;
      bus_addr  <= a;
      bus_data  <= d;
      bus_read  <= rd;
      bus_word  <= wd;
      @(posedge pclk);
      bus_valid <= 1'b0;
      bus_addr  <= ~a;
      bus_data  <= ~d;
      bus_read  <= ~rd;
      bus_word  <= ~wd;
   endtask
endmodule // cpu_bus_model

// ### verif/match_cmp_chk.sv
`timescale 1ns/1ps
// watches config writes and match pulses
module match_cmp_chk
   import match_cmp_pkg::*;
(
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [11:0]       paddr,
   input wire logic [31:0]       pwdata,
   input wire logic              pready,
   input wire logic              bus_valid,
   input wire logic [ADDR_W-1:0] bus_addr,
   input wire logic              bus_read,
   input wire logic              bus_word,
   input wire logic              background_debug_state,
   input wire logic              background_debug_access,
   input wire logic [NUM_CH-1:0] match_forced,
   input wire logic [NUM_CH-1:0] match_tag_request,
   input wire logic              halt_request
);
   logic [31:0] sh_ff [0:8];
   logic        range_on;
   logic        inside_on;

   // shadow of completed config writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 9; i++) begin
            sh_ff[i] <= '0;
         end
      end else if (psel && penable && pwrite && pready && paddr < OFF_STATUS) begin
         sh_ff[paddr[5:2]] <= pwdata;
      end
   end

   // window needs a mode and both enables
   assign range_on = (sh_ff[8][1:0] == RANGE_INSIDE || sh_ff[8][1:0] == RANGE_OUTSIDE)
                     && sh_ff[0][BIT_ENABLE] && sh_ff[1][BIT_ENABLE];
   assign inside_on = range_on && sh_ff[8][1:0] == RANGE_INSIDE;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_third_exact: assert property (
      match_forced[2] |-> $past(bus_valid && bus_addr == sh_ff[5][ADDR_W-1:0]))
      else $error("third channel fired away from its address");
   a_third_dir: assert property (
      bus_valid && !background_debug_state && !background_debug_access
      && sh_ff[2][BIT_ENABLE] && !sh_ff[2][BIT_TAG] && bus_addr == sh_ff[5][ADDR_W-1:0]
      && (!sh_ff[2][BIT_DIR_QUAL] || sh_ff[2][BIT_DIR_READ] == bus_read) |=> match_forced[2])
      else $error("third channel missed a qualifying cycle");
   a_third_dirblk: assert property (
      match_forced[2] |-> $past(!sh_ff[2][BIT_DIR_QUAL] || sh_ff[2][BIT_DIR_READ] == bus_read))
      else $error("third channel fired on the wrong direction");
   a_size_qual: assert property (
      match_forced[1] |-> $past(!sh_ff[1][BIT_SZ_QUAL] || sh_ff[1][BIT_SZ_BYTE] != bus_word))
      else $error("second channel fired on the wrong size");
   a_pair_single: assert property (
      range_on |=> !match_forced[1] && !match_tag_request[1])
      else $error("second channel fired while paired");
   a_inside_win: assert property (
      match_forced[0] && $past(inside_on) |->
      $past(bus_addr >= sh_ff[3][ADDR_W-1:0] && bus_addr <= sh_ff[4][ADDR_W-1:0]))
      else $error("inside window hit outside the bounds");
   a_outside_win: assert property (
      match_forced[0] && $past(range_on && !inside_on) |->
      $past(bus_addr < sh_ff[3][ADDR_W-1:0] || bus_addr > sh_ff[4][ADDR_W-1:0]))
      else $error("outside window hit inside the bounds");
   a_range_dir: assert property (
      match_forced[0] && $past(range_on) |->
      $past(!sh_ff[0][BIT_DIR_QUAL] || sh_ff[0][BIT_DIR_READ] == bus_read))
      else $error("window hit on the wrong direction");
   a_debug_quiet: assert property (
      background_debug_state || background_debug_access |=>
      !(|match_forced) && !(|match_tag_request) && !halt_request)
      else $error("match during background debug");
   a_tag_exact: assert property (
      match_tag_request[2] |-> $past(bus_addr == sh_ff[5][ADDR_W-1:0]))
      else $error("tag request away from the exact address");
   a_halt_cause: assert property (
      halt_request |-> ((|match_forced) || (|match_tag_request))
      && $past(sh_ff[0][BIT_HALT] || sh_ff[2][BIT_HALT] || !range_on && sh_ff[1][BIT_HALT]))
      else $error("halt request without a hit");
endmodule // match_cmp_chk

bind debug_bus_match_comparators match_cmp_chk match_cmp_chk_inst (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
   .bus_valid, .bus_addr, .bus_read, .bus_word, .background_debug_state,
   .background_debug_access, .match_forced, .match_tag_request, .halt_request
);

// ### verif/tb.sv
`timescale 1ns/1ps
// apb and cpu bus stimulus, pulse checks
module tb
   import match_cmp_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic bus_valid, bus_read, bus_word, halt_request;
   logic background_debug_state, background_debug_access;
   logic [ADDR_W-1:0] bus_addr;
   logic [DATA_W-1:0] bus_data;
   logic [NUM_CH-1:0] match_forced, match_tag_request;
   int n_errors = 0;
   int checks = 0;
   int cyc = 0;
   logic [15:0] msk [9] = '{16'h0000, 16'hff00, 16'hff00, 16'h00ff, 16'hffff,
                            16'hffff, 16'h0000, 16'hffff, 16'hffff};
   logic [15:0] dat [9] = '{16'h1234, 16'ha5ff, 16'h5a5a, 16'hff5a, 16'ha55a,
                            16'ha55b, 16'ha55a, 16'ha55b, 16'ha55a};
   logic [ADDR_W-1:0] ra [9] = '{18'h01000, 18'h00fff, 18'h01010, 18'h01011, 18'h01005,
                                 18'h00fff, 18'h01011, 18'h01008, 18'h01000};

   debug_bus_match_comparators debug_bus_match_comparators_inst (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .bus_valid, .bus_addr, .bus_data, .bus_read, .bus_word,
      .background_debug_state, .background_debug_access, .match_forced,
      .match_tag_request, .halt_request);
   cpu_bus_model cpu_bus_model_inst (
      .pclk, .bus_valid, .bus_addr, .bus_data, .bus_read, .bus_word);

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // a hang ends in the same report
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_errors++;
         conclude();
      end
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one apb transfer, held until pready is high
   task automatic apb(input int wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr[0];
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // one bus cycle; pulses sampled just after the next edge
   task automatic hit(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      input logic r, input logic w, input logic [6:0] exp);
      cpu_bus_model_inst.cycle(a, d, r, w);
      #1;
      chk({25'h0, halt_request, match_tag_request, match_forced}, {25'h0, exp});
   endtask

   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {background_debug_state, background_debug_access} = 2'b00;
      presetn = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, 12'h030, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1, OFF_ADDR_C, 32'h01235);
      apb(0, OFF_ADDR_C, 32'h0);
      chk(rd, 32'h01235);
      // third comparator: each direction setting
      for (int i = 0; i < 3; i++) begin
         apb(1, OFF_CTRL_C, (i == 0) ? 32'h01 : ((i == 1) ? 32'h03 : 32'h07));
         for (int r = 0; r < 2; r++) begin
            hit(18'h01235, 16'h0, r[0], 1'b0, {4'h0, i == 0 || (i == 2) == r[0], 2'b00});
         end
      end
      hit(18'h01234, 16'h0, 1'b1, 1'b1, 7'h00);
      $display("third comparator test done");
      // second comparator: size qualify off, word only, byte only
      apb(1, OFF_ADDR_B, 32'h00400);
      for (int i = 0; i < 3; i++) begin
         apb(1, OFF_CTRL_B, (i == 0) ? 32'h01 : ((i == 1) ? 32'h09 : 32'h19));
         for (int w = 0; w < 2; w++) begin
            hit(18'h00400, 16'h0, 1'b1, w[0], {5'h0, i == 0 || (i == 2) != w[0], 1'b0});
         end
      end
      $display("second comparator test done");
      // first comparator: masks and both data modes on word reads
      apb(1, OFF_ADDR_A, 32'h00800);
      apb(1, OFF_DATA_CMP, 32'ha55a);
      for (int i = 0; i < 9; i++) begin
         apb(1, OFF_DATA_MASK, {16'h0, msk[i]});
         apb(1, OFF_CTRL_A, (i > 5) ? 32'h81 : 32'h01);
         hit(18'h00800, dat[i], 1'b1, 1'b1, {6'h0, 1'(9'b010011011 >> i)});
      end
      $display("data compare test done");
      // window: second's direction, size and halt bits ignored
      apb(1, OFF_DATA_MASK, 32'h0);
      apb(1, OFF_ADDR_A, 32'h01000);
      apb(1, OFF_ADDR_B, 32'h01010);
      apb(1, OFF_CTRL_A, 32'h07);
      apb(1, OFF_CTRL_B, 32'h5b);
      for (int i = 0; i < 9; i++) begin
         apb(1, OFF_RANGE, (i < 5) ? {30'h0, RANGE_INSIDE} : {30'h0, RANGE_OUTSIDE});
         hit(ra[i], 16'h0, i != 4, 1'b1, {6'h0, 1'(9'b001100101 >> i)});
      end
      apb(1, OFF_CTRL_A, 32'h47);
      hit(18'h00fff, 16'h0, 1'b1, 1'b0, 7'h41);
      apb(1, OFF_ADDR_A, 32'h0);
      hit(18'h00000, 16'h0, 1'b1, 1'b0, 7'h00);
      apb(1, OFF_CTRL_A, 32'h0);
      apb(1, OFF_CTRL_B, 32'h0);
      hit(18'h00fff, 16'h0, 1'b1, 1'b1, 7'h00);
      $display("window test done");
      // tagging drops the direction qualifier
      apb(1, OFF_CTRL_C, 32'h23);
      hit(18'h01235, 16'h0, 1'b1, 1'b0, 7'h20);
      // background debug blocks everything
      apb(1, OFF_CTRL_C, 32'h01);
      background_debug_state <= 1'b1;
      hit(18'h01235, 16'h0, 1'b0, 1'b0, 7'h00);
      background_debug_state  <= 1'b0;
      background_debug_access <= 1'b1;
      hit(18'h01235, 16'h0, 1'b0, 1'b0, 7'h00);
      background_debug_access <= 1'b0;
      hit(18'h01235, 16'h0, 1'b0, 1'b0, 7'h04);
      $display("tag and debug test done");
      conclude();
   end
endmodule // tb
